// ===== logic/remote_pulse_width_receiver.sv
// Summary of operation
// - Guide high too short or too long at its fall: discard, wait next rise.
// - Guide high within range: raise guide-detect, start data low measurement.
// - Data low ending short at a rise: error, measure guide high again.
// - Data low within range at a rise: measure following data high.
// - Data low reaching long threshold while low: start end-width count.
// - Data high ending below bit-0 short: error, wait next rise.
// - Data high within bit-0 window: shift in 0, measure next low.
// - Data high between bit-0 long and bit-1 short: error, wait next rise.
// - Data high within bit-1 window: shift in 1, measure next low.
// - Data high reaching bit-1 long while high: error now, wait next rise.
// - Threshold change putting high count at or above bit-1 long: error.
// - Rise during end-width count before threshold: error, measure guide.
// - End-width count reaching threshold: reception-end, halt until shift read.
// - No error event before a valid guide pulse.
// - One error event only until the next valid guide pulse.
// - Least low after last bit is data-low long+1 plus end width+1.
// - Operation clock is source clock, or half of it when halving selected.
// - Pin resynchronised to operation clock, first stage one clock later.
// - Later stages latch the previous stage only when it agrees.
// - Noise width picks second or third stage as the filtered input.
// - An error clears shift register and received-bit count at once.
// - Full shift register moves to data buffer, buffer-full, shift cleared.
// - Shift read after reception end clears shift and count, resumes.
`timescale 1ns/1ps
`default_nettype none

module remote_pulse_width_receiver (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic remoteInputPin,
  input wire remote_rx_pkg::apb_req_t apbReq,
  output remote_rx_pkg::apb_rsp_t apbRsp,
  output remote_rx_pkg::events_t events
);

  // --------------------------------------------------
  // Decode helpers
  // --------------------------------------------------
  function automatic logic isThr(input logic [7:0] addr);
    return (addr >= remote_rx_pkg::OFF_THR_FIRST) && (addr <= remote_rx_pkg::OFF_THR_LAST)
      && (addr[1:0] == 2'h0);
  endfunction : isThr

  function automatic logic [3:0] thrIndex(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - remote_rx_pkg::OFF_THR_FIRST;
    return d[5:2];
  endfunction : thrIndex

  remote_rx_pkg::regs_t r;
  remote_rx_pkg::regs_t next_r;

  logic en;
  logic tick;
  logic filt;
  logic rise;
  logic fall;
  logic access;
  logic wrDone;
  logic rdDone;
  logic mapped;
  logic errNow;
  logic shiftNow;
  logic bitVal;
  logic [7:0] cntInc;
  logic [7:0] newShift;
  logic [7:0] rdByte;
  remote_rx_pkg::thr_t t;

  assign en = r.ctrl[remote_rx_pkg::CTRL_EN_BIT];
  assign t = r.thr;
  // Halved clock is a one-in-two enable, keeping a single clock domain
  assign tick = ~r.ctrl[remote_rx_pkg::CTRL_HALVE_BIT] | r.phase;
  assign filt = r.ctrl[remote_rx_pkg::CTRL_NOISE_WIDTH_BIT] ? r.thirdSampleStage
    : r.secondSampleStage;
  assign rise = filt & ~r.prevFilt;
  assign fall = ~filt & r.prevFilt;
  assign access = apbReq.psel & apbReq.penable;
  assign wrDone = access & r.rsp.pready & apbReq.pwrite;
  assign rdDone = access & r.rsp.pready & ~apbReq.pwrite;
  assign mapped = isThr(apbReq.paddr) || (apbReq.paddr == remote_rx_pkg::OFF_CTRL)
    || (apbReq.paddr == remote_rx_pkg::OFF_SHIFT) || (apbReq.paddr == remote_rx_pkg::OFF_COUNT)
    || (apbReq.paddr == remote_rx_pkg::OFF_DATA) || (apbReq.paddr == remote_rx_pkg::OFF_STATUS);

  // --------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------
  always_comb begin
    rdByte = 8'h00;
    if (isThr(apbReq.paddr)) begin
      rdByte = r.thr[8 * (remote_rx_pkg::THR_LAST_IDX - int'(thrIndex(apbReq.paddr))) +: 8];
    end else if (apbReq.paddr == remote_rx_pkg::OFF_CTRL) begin
      rdByte = r.ctrl;
    end else if (apbReq.paddr == remote_rx_pkg::OFF_SHIFT) begin
      rdByte = r.shiftReg;
    end else if (apbReq.paddr == remote_rx_pkg::OFF_COUNT) begin
      rdByte = r.bitCount;
    end else if (apbReq.paddr == remote_rx_pkg::OFF_DATA) begin
      rdByte = r.dataBuf;
    end else if (apbReq.paddr == remote_rx_pkg::OFF_STATUS) begin
      rdByte = {r.state, r.armed, filt};
    end
  end

  // --------------------------------------------------
  // Next state
  // --------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.ev = '0;
    errNow = 1'b0;
    shiftNow = 1'b0;
    bitVal = 1'b0;
    cntInc = (r.cnt == remote_rx_pkg::CNT_MAX) ? r.cnt : r.cnt + 8'h01;
    newShift = 8'h00;

    // APB slave, one wait state
    if (access && !r.rsp.pready) begin
      next_r.rsp.pready = 1'b1;
      next_r.rsp.pslverr = ~mapped;
      next_r.rsp.prdata = {24'h000000, rdByte};
    end else begin
      next_r.rsp = '0;
    end

    next_r.phase = r.ctrl[remote_rx_pkg::CTRL_HALVE_BIT] ? ~r.phase : 1'b0;

    if (!en) begin
      next_r.state = remote_rx_pkg::ST_IDLE;
      next_r.shiftReg = 8'h00;
      next_r.bitCount = 8'h00;
      next_r.dataBuf = 8'h00;
      next_r.cnt = 8'h00;
      next_r.armed = 1'b0;
      next_r.syncIn = 1'b0;
      next_r.firstSampleStage = 1'b0;
      next_r.secondSampleStage = 1'b0;
      next_r.thirdSampleStage = 1'b0;
      next_r.prevFilt = 1'b0;
    end else if (tick) begin
      // Noise filter: stages after the first move only when their input agrees for a clock
      next_r.syncIn = remoteInputPin;
      next_r.firstSampleStage = r.syncIn;
      if (r.syncIn == r.firstSampleStage) begin
        next_r.secondSampleStage = r.firstSampleStage;
      end
      if (r.syncIn == r.secondSampleStage) begin
        next_r.thirdSampleStage = r.secondSampleStage;
      end
      next_r.prevFilt = filt;
      next_r.cnt = cntInc;

      unique case (r.state)
        remote_rx_pkg::ST_IDLE: begin
          if (rise) begin
            next_r.state = remote_rx_pkg::ST_GUIDE;
            next_r.cnt = 8'h00;
          end
        end
        remote_rx_pkg::ST_GUIDE: begin
          if (fall) begin
            next_r.cnt = 8'h00;
            if (r.cnt >= t.guideShort && r.cnt < t.guideLong) begin
              next_r.ev.guideDetect = 1'b1;
              next_r.armed = 1'b1;
              next_r.state = remote_rx_pkg::ST_DLOW;
            end else begin
              next_r.state = remote_rx_pkg::ST_IDLE;
            end
          end
        end
        remote_rx_pkg::ST_DLOW: begin
          if (rise) begin
            next_r.cnt = 8'h00;
            if (r.cnt < t.dataLowShort) begin
              errNow = 1'b1;
              next_r.state = remote_rx_pkg::ST_GUIDE;
            end else begin
              next_r.state = remote_rx_pkg::ST_DHIGH;
            end
          end else if (r.cnt >= t.dataLowLong) begin
            // Starting at one keeps the closing low at data-low long+1 plus end width+1
            next_r.cnt = 8'h01;
            next_r.state = remote_rx_pkg::ST_ENDW;
          end
        end
        remote_rx_pkg::ST_DHIGH: begin
          if (fall) begin
            next_r.cnt = 8'h00;
            next_r.state = remote_rx_pkg::ST_IDLE;
            if (r.cnt < t.bit0Short) begin
              errNow = 1'b1;
            end else if (r.cnt < t.bit0Long) begin
              shiftNow = 1'b1;
              next_r.state = remote_rx_pkg::ST_DLOW;
            end else if (r.cnt < t.bit1Short) begin
              errNow = 1'b1;
            end else if (r.cnt < t.bit1Long) begin
              shiftNow = 1'b1;
              bitVal = 1'b1;
              next_r.state = remote_rx_pkg::ST_DLOW;
            end else begin
              errNow = 1'b1;
            end
          end else if (r.cnt >= t.bit1Long) begin
            // Also catches a threshold lowered under a running count
            errNow = 1'b1;
            next_r.state = remote_rx_pkg::ST_IDLE;
          end
        end
        remote_rx_pkg::ST_ENDW: begin
          if (rise) begin
            errNow = 1'b1;
            next_r.cnt = 8'h00;
            next_r.state = remote_rx_pkg::ST_GUIDE;
          end else if (r.cnt >= t.endWidth) begin
            next_r.ev.receptionEnd = 1'b1;
            next_r.state = remote_rx_pkg::ST_HALT;
          end
        end
        remote_rx_pkg::ST_HALT: begin
          next_r.cnt = r.cnt;
        end
        default: begin
          next_r.state = remote_rx_pkg::ST_IDLE;
        end
      endcase

      if (errNow) begin
        next_r.ev.receptionError = r.armed;
        next_r.armed = 1'b0;
        next_r.shiftReg = 8'h00;
        next_r.bitCount = 8'h00;
      end
      if (shiftNow) begin
        // First bit received ends in bit 0 once the byte is complete
        newShift = {bitVal, r.shiftReg[7:1]};
        next_r.bitCount = r.bitCount + 8'h01;
        if (r.bitCount[2:0] == remote_rx_pkg::LAST_BIT_OF_BYTE) begin
          next_r.dataBuf = newShift;
          next_r.ev.bufferFull = 1'b1;
          next_r.shiftReg = 8'h00;
        end else begin
          next_r.shiftReg = newShift;
        end
      end
    end

    // Software effects take effect on the completing APB edge
    if (rdDone && en && apbReq.paddr == remote_rx_pkg::OFF_SHIFT
        && r.state == remote_rx_pkg::ST_HALT) begin
      next_r.shiftReg = 8'h00;
      next_r.bitCount = 8'h00;
      next_r.cnt = 8'h00;
      next_r.state = remote_rx_pkg::ST_IDLE;
    end
    if (wrDone && apbReq.paddr == remote_rx_pkg::OFF_CTRL) begin
      next_r.ctrl = apbReq.pwdata[7:0];
    end
    // Writes are not blocked while enabled; software is trusted to stop first
    if (wrDone && isThr(apbReq.paddr)) begin
      next_r.thr[8 * (remote_rx_pkg::THR_LAST_IDX - int'(thrIndex(apbReq.paddr))) +: 8] =
        apbReq.pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= remote_rx_pkg::REGS_RST;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign apbRsp = r.rsp;
  assign events = r.ev;

  // --------------------------------------------------
  // Checks
  // --------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic step;
  assign step = clkEn && en && tick;

  property p_guide_bad;
    step && r.state == remote_rx_pkg::ST_GUIDE && fall
      && (r.cnt < t.guideShort || r.cnt >= t.guideLong)
      |=> r.state == remote_rx_pkg::ST_IDLE && !r.ev.guideDetect;
  endproperty
  a_guide_bad: assert property (p_guide_bad) else $error("bad guide not discarded");

  property p_guide_ok;
    step && r.state == remote_rx_pkg::ST_GUIDE && fall
      && r.cnt >= t.guideShort && r.cnt < t.guideLong
      |=> r.ev.guideDetect && r.armed && r.state == remote_rx_pkg::ST_DLOW && r.cnt == 8'h00;
  endproperty
  a_guide_ok: assert property (p_guide_ok) else $error("valid guide not taken");

  property p_low_short;
    step && r.state == remote_rx_pkg::ST_DLOW && rise && r.cnt < t.dataLowShort && r.armed
      |=> r.ev.receptionError && r.state == remote_rx_pkg::ST_GUIDE;
  endproperty
  a_low_short: assert property (p_low_short) else $error("short low not flagged");

  property p_low_ok;
    step && r.state == remote_rx_pkg::ST_DLOW && rise && r.cnt >= t.dataLowShort
      && r.cnt < t.dataLowLong |=> r.state == remote_rx_pkg::ST_DHIGH && r.cnt == 8'h00;
  endproperty
  a_low_ok: assert property (p_low_ok) else $error("data high not started");

  property p_low_long;
    step && r.state == remote_rx_pkg::ST_DLOW && !rise && r.cnt >= t.dataLowLong
      |=> r.state == remote_rx_pkg::ST_ENDW && r.cnt == 8'h01;
  endproperty
  a_low_long: assert property (p_low_long) else $error("end width not started");

  property p_bit_in;
    step && r.state == remote_rx_pkg::ST_DHIGH && fall && r.cnt >= t.bit0Short
      && r.cnt < t.bit0Long
      |=> r.bitCount == $past(r.bitCount) + 8'h01 && r.state == remote_rx_pkg::ST_DLOW;
  endproperty
  a_bit_in: assert property (p_bit_in) else $error("bit 0 not shifted");

  property p_bit_one;
    step && r.state == remote_rx_pkg::ST_DHIGH && fall && r.cnt >= t.bit1Short
      && r.cnt < t.bit1Long
      |=> r.bitCount == $past(r.bitCount) + 8'h01 && (r.shiftReg[7] || r.dataBuf[7]);
  endproperty
  a_bit_one: assert property (p_bit_one) else $error("bit 1 not shifted");

  property p_high_err;
    step && r.state == remote_rx_pkg::ST_DHIGH && fall && r.armed
      && (r.cnt < t.bit0Short || (r.cnt >= t.bit0Long && r.cnt < t.bit1Short))
      |=> r.ev.receptionError && r.state == remote_rx_pkg::ST_IDLE && r.bitCount == 8'h00;
  endproperty
  a_high_err: assert property (p_high_err) else $error("bad high not flagged");

  property p_high_long;
    step && r.state == remote_rx_pkg::ST_DHIGH && !fall && r.cnt >= t.bit1Long && r.armed
      |=> r.ev.receptionError && r.state == remote_rx_pkg::ST_IDLE;
  endproperty
  a_high_long: assert property (p_high_long) else $error("long high not flagged");

  property p_end;
    step && r.state == remote_rx_pkg::ST_ENDW && !rise && r.cnt >= t.endWidth
      |=> r.ev.receptionEnd ##1 (r.state == remote_rx_pkg::ST_HALT || !en || $past(rdDone));
  endproperty
  a_end: assert property (p_end) else $error("reception end not raised");

  property p_err_armed;
    $rose(r.ev.receptionError) |-> $past(r.armed) && !r.armed;
  endproperty
  a_err_armed: assert property (p_err_armed) else $error("error without guide");

  property p_err_once;
    $rose(r.armed) |-> r.ev.guideDetect;
  endproperty
  a_err_once: assert property (p_err_once) else $error("error mask lifted without guide");

  property p_err_clear;
    r.ev.receptionError |-> r.shiftReg == 8'h00 && r.bitCount == 8'h00;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error left bits");

  property p_full;
    r.ev.bufferFull |-> r.shiftReg == 8'h00 && r.bitCount[2:0] == 3'h0;
  endproperty
  a_full: assert property (p_full) else $error("full byte not moved");

  property p_resume;
    clkEn && rdDone && en && apbReq.paddr == remote_rx_pkg::OFF_SHIFT
      && r.state == remote_rx_pkg::ST_HALT
      |=> r.state == remote_rx_pkg::ST_IDLE && r.bitCount == 8'h00;
  endproperty
  a_resume: assert property (p_resume) else $error("halt not released");

endmodule : remote_pulse_width_receiver

`default_nettype wire

// ===== logic/remote_rx_pkg.sv
package remote_rx_pkg;

  // --------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_THR_FIRST = 8'h04;
  localparam logic [7:0] OFF_THR_LAST = 8'h24;
  localparam logic [7:0] OFF_SHIFT = 8'h28;
  localparam logic [7:0] OFF_COUNT = 8'h2c;
  localparam logic [7:0] OFF_DATA = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h34;
  localparam int THR_LAST_IDX = 8;

  // --------------------------------------------------
  // Control fields and counter limits
  // --------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_NOISE_WIDTH_BIT = 1;
  localparam int CTRL_HALVE_BIT = 2;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_GUIDE = 6'h02,
    ST_DLOW = 6'h04,
    ST_DHIGH = 6'h08,
    ST_ENDW = 6'h10,
    ST_HALT = 6'h20
  } rx_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic guideDetect;
    logic receptionError;
    logic receptionEnd;
    logic bufferFull;
  } events_t;

  // Field order fixes the threshold index: guide short is index 0
  typedef struct packed {
    logic [7:0] guideShort;
    logic [7:0] guideLong;
    logic [7:0] dataLowShort;
    logic [7:0] dataLowLong;
    logic [7:0] bit0Short;
    logic [7:0] bit0Long;
    logic [7:0] bit1Short;
    logic [7:0] bit1Long;
    logic [7:0] endWidth;
  } thr_t;

  typedef struct packed {
    rx_state_t state;
    logic [7:0] ctrl;
    thr_t thr;
    logic [7:0] shiftReg;
    logic [7:0] bitCount;
    logic [7:0] dataBuf;
    logic [7:0] cnt;
    logic phase;
    logic syncIn;
    logic firstSampleStage;
    logic secondSampleStage;
    logic thirdSampleStage;
    logic prevFilt;
    logic armed;
    apb_rsp_t rsp;
    events_t ev;
  } regs_t;

  localparam regs_t REGS_RST = '{state: ST_IDLE, default: '0};

endpackage : remote_rx_pkg

// ===== test/remote_source.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Remote signal source
// ----------------------------------------
// Idle level is low, since every frame opens with a high guide pulse
module remote_source (
  input wire logic clk_sys,
  output logic pin
);
  initial pin = 1'b0;

  // Level changes land just after a rising edge, never mid-cycle
  task automatic drive(input logic lvl, input int cycles);
    pin <= lvl;
    repeat (cycles) @(posedge clk_sys);
  endtask : drive
endmodule : remote_source

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Bench top
// ----------------------------------------
module testbench;
  typedef struct {int g; int l1; int h1; int l2; int gd; int er;} row_t;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic pin;
  remote_rx_pkg::apb_req_t apbReq = '0;
  remote_rx_pkg::apb_rsp_t apbRsp;
  remote_rx_pkg::events_t events;
  int failures = 0;
  int tests_run = 0;
  int gdCnt = 0;
  int errCnt = 0;
  int endCnt = 0;
  int fullCnt = 0;
  int scale = 1;
  int g0;
  int e0;
  logic [31:0] rd;
  logic se;
  // Pin widths in operation ticks; margins of two ticks absorb filter jitter
  row_t rows [9] = '{
    '{5, 8, 6, 8, 0, 0},
    '{25, 8, 6, 8, 0, 0},
    '{15, 2, 6, 8, 1, 1},
    '{15, 8, 2, 8, 1, 1},
    '{15, 8, 10, 8, 1, 1},
    '{15, 8, 25, 8, 1, 1},
    '{15, 15, 6, 8, 1, 1},
    '{15, 8, 6, 2, 1, 1},
    '{15, 8, 15, 2, 1, 1}
  };
  logic [7:0] thr [9] = '{8'h0a, 8'h14, 8'h04, 8'h0c, 8'h04, 8'h08, 8'h0c, 8'h12, 8'h08};

  always #20 clk_sys = ~clk_sys;

  remote_source src_u (.clk_sys(clk_sys), .pin(pin));

  remote_pulse_width_receiver dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .remoteInputPin(pin),
    .apbReq(apbReq), .apbRsp(apbRsp), .events(events));

  // Events are one-cycle pulses, so they are tallied at every edge
  always @(posedge clk_sys) begin
    if (events.guideDetect === 1'b1) gdCnt <= gdCnt + 1;
    if (events.receptionError === 1'b1) errCnt <= errCnt + 1;
    if (events.receptionEnd === 1'b1) endCnt <= endCnt + 1;
    if (events.bufferFull === 1'b1) fullCnt <= fullCnt + 1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    rd = apbRsp.prdata;
    se = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("[ERR] %0t no bus answer", $time);
      results();
    end
  endtask : apb

  // Guide, then bits first-sent first, then a long closing low
  task automatic frame(input logic [10:0] bits, input int n);
    src_u.drive(1'b1, 15 * scale);
    for (int i = 0; i < n; i++) begin
      src_u.drive(1'b0, 8 * scale);
      src_u.drive(1'b1, (bits[i] ? 15 : 6) * scale);
    end
    src_u.drive(1'b0, 40 * scale);
  endtask : frame

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, remote_rx_pkg::OFF_CTRL, '0);
    check(rd, 32'h0);
    apb(1'b0, 8'h3c, '0);
    check({31'h0, se}, 32'h1);
    // Thresholds only while disabled, in legal order
    for (int i = 0; i < 9; i++) apb(1'b1, 8'h04 + 8'(4 * i), {24'h0, thr[i]});
    apb(1'b0, remote_rx_pkg::OFF_THR_LAST, '0);
    check(rd, 32'h8);
    apb(1'b1, remote_rx_pkg::OFF_CTRL, 32'h1);
    foreach (rows[i]) begin
      g0 = gdCnt;
      e0 = errCnt;
      src_u.drive(1'b1, rows[i].g);
      src_u.drive(1'b0, rows[i].l1);
      src_u.drive(1'b1, rows[i].h1);
      src_u.drive(1'b0, rows[i].l2);
      src_u.drive(1'b1, 4);
      src_u.drive(1'b0, 40);
      check(gdCnt - g0, rows[i].gd);
      check(errCnt - e0, rows[i].er);
      apb(1'b0, remote_rx_pkg::OFF_COUNT, '0);
      check(rd, 32'h0);
    end
    // Clock enable low freezes the guide count: 35 cycles high measure as 15
    g0 = gdCnt;
    e0 = errCnt;
    src_u.drive(1'b1, 8);
    clkEn <= 1'b0;
    src_u.drive(1'b1, 20);
    clkEn <= 1'b1;
    src_u.drive(1'b1, 7);
    src_u.drive(1'b0, 2);
    src_u.drive(1'b1, 4);
    src_u.drive(1'b0, 40);
    check(gdCnt - g0, 1);
    check(errCnt - e0, 1);
    // Shortest closing low that still ends reception, then one tick less
    for (int w = 22; w >= 21; w--) begin
      e0 = endCnt;
      g0 = errCnt;
      src_u.drive(1'b1, 15);
      src_u.drive(1'b0, 8);
      src_u.drive(1'b1, 6);
      src_u.drive(1'b0, w);
      src_u.drive(1'b1, 4);
      src_u.drive(1'b0, 40);
      check(endCnt - e0, w - 21);
      check(errCnt - g0, 22 - w);
      apb(1'b0, remote_rx_pkg::OFF_SHIFT, '0);
      check(rd, 32'h0);
    end
    // Full frames at plain clock and at halved clock with wider filter
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, remote_rx_pkg::OFF_CTRL, 32'h0);
      apb(1'b1, remote_rx_pkg::OFF_CTRL, k ? 32'h7 : 32'h1);
      scale = k + 1;
      g0 = gdCnt;
      e0 = endCnt;
      frame(11'h5a5, 11);
      check(gdCnt - g0, 1);
      check(endCnt - e0, 1);
      check(fullCnt, k + 1);
      apb(1'b0, remote_rx_pkg::OFF_DATA, '0);
      check(rd, 32'ha5);
      frame(11'h5a5, 11);
      check(gdCnt - g0, 1);
      apb(1'b0, remote_rx_pkg::OFF_COUNT, '0);
      check(rd, 32'hb);
      apb(1'b0, remote_rx_pkg::OFF_SHIFT, '0);
      check(rd, 32'ha0);
      apb(1'b0, remote_rx_pkg::OFF_COUNT, '0);
      check(rd, 32'h0);
    end
    // Reset in mid-run returns control and thresholds to zero
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, remote_rx_pkg::OFF_CTRL, '0);
    check(rd, 32'h0);
    apb(1'b0, remote_rx_pkg::OFF_THR_FIRST, '0);
    check(rd, 32'h0);
    results();
  end
endmodule : testbench

`default_nettype wire
